// *** icc_regs.vh ***
`ifndef ICC_REGS_VH
`define ICC_REGS_VH
// Register offsets (word addresses on the plain port).
`define ICC_ADDR_W 5
`define ICC_CTRL_BASE 5'h00
`define ICC_BUF_BASE 5'h08
`define ICC_IRQ_STAT 5'h10
`define ICC_IRQ_EN 5'h11
`define ICC_IRQ_CLR 5'h12
// Control register fields.
`define ICC_MODE_LSB 0
`define ICC_BNE_BIT 3
`define ICC_OVF_BIT 4
`define ICC_CPI_LSB 5
`define ICC_TSEL_BIT 7
`define ICC_SIDL_BIT 13
`define ICC_CTRL_WMASK 16'h20e7
`define ICC_CTRL_RESET 16'h0000
// Capture mode encodings.
`define ICC_MODE_OFF 3'h0
`define ICC_MODE_BOTH 3'h1
`define ICC_MODE_FALL 3'h2
`define ICC_MODE_RISE 3'h3
`define ICC_MODE_DIV4 3'h4
`define ICC_MODE_DIV16 3'h5
`define ICC_MODE_UNUSED 3'h6
`define ICC_MODE_WAKE 3'h7
// Edge prescaler terminal counts.
`define ICC_DIV4_LAST 4'h3
`define ICC_DIV16_LAST 4'hf
`endif

// *** icc_sync.v ***
// ****************************************
// Two-stage pin synchroniser
// ****************************************
module icc_sync (
  input wire sys_clk,
  input wire nrst,
  input wire pin_in,
  output reg pin_sync_q
);
  reg meta_q;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      pin_sync_q <= meta_q;
    end
  end
endmodule // icc_sync

// *** icc_fifo.v ***
`include "icc_regs.vh"
// ****************************************
// Four-word capture buffer
// ****************************************
module icc_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire sys_clk,
  input wire nrst,
  input wire clear,
  input wire push,
  input wire [WIDTH-1:0] push_data,
  input wire pop,
  output wire [WIDTH-1:0] head_data,
  output wire not_empty,
  output wire full
);
  localparam [AW:0] DEPTH_C = DEPTH;
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire do_push;
  wire do_pop;
  assign full = (cnt_q == DEPTH_C);
  assign not_empty = (cnt_q != {(AW+1){1'b0}});
  assign do_push = push && !full;
  assign do_pop = pop && not_empty;
  assign head_data = mem_q[rd_q];
  always @(posedge sys_clk) begin
    if (do_push) begin
      mem_q[wr_q] <= push_data;
    end
  end
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (clear) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // icc_fifo

// *** icc_capture.v ***
// The implementer's own choices: the strobed register port and the register offsets.
`include "icc_regs.vh"
// ****************************************
// Input capture block, NCH channels
// ****************************************
// Functional notes
// [RULE1] Event latches selected 16-bit time base
// [RULE2] Modes 001 both, 010 fall, 011 rise
// [RULE3] Modes 100/101 every 4th/16th rise
// [RULE4] Modes 000 and 110 disable channel
// [RULE5] Mode 111 rising wake interrupt only
// [RULE6] Interrupt every 1 to 4 captures
// [RULE7] Every-edge mode ignores captures-per-interrupt
// [RULE8] Four-deep FIFO read in capture order
// [RULE9] Not-empty flag read-only, hardware cleared
// [RULE10] Overflow flag read-only, hardware cleared
// [RULE11] Select one picks time base A
// [RULE12] Idle-stop halts channel in Idle
// [RULE13] Pin event wakes from Sleep, Idle
// [RULE14] DMA requests on first two channels only
// [RULE15] Up to eight identical channels
// [RULE16] Unimplemented control bits read zero
// [RULE17] Overflow on full push, cleared when empty
// [RULE18] Pin synchronised with two flip-flops
module icc_capture #(
  parameter NCH = 8,
  parameter WIDTH = 16
) (
  input wire sys_clk,
  input wire nrst,
  input wire [`ICC_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire [NCH-1:0] capture_input_pin,
  input wire [WIDTH-1:0] time_base_a_count,
  input wire [WIDTH-1:0] time_base_b_count,
  input wire cpu_idle,
  input wire cpu_sleep,
  output wire irq,
  output wire wake_req,
  output reg [1:0] dma_req
);
  // ****************************************
  // Shared interrupt registers
  // ****************************************
  reg [NCH-1:0] irq_stat_q;
  reg [NCH-1:0] irq_en_q;
  wire [NCH-1:0] ch_event;
  wire [NCH-1:0] ch_wake;
  wire [NCH-1:0] ch_capture;
  wire [15:0] ch_ctrl_rd [0:NCH-1];
  wire [WIDTH-1:0] ch_head [0:NCH-1];
  wire sel_stat;
  wire sel_en;
  wire sel_clr;
  assign sel_stat = (reg_addr == `ICC_IRQ_STAT);
  assign sel_en = (reg_addr == `ICC_IRQ_EN);
  assign sel_clr = (reg_addr == `ICC_IRQ_CLR);
  // ****************************************
  // Channels
  // ****************************************
  genvar g;
  generate
    // [RULE15] per-channel replication
    for (g = 0; g < NCH; g = g + 1) begin : gch
      localparam [`ICC_ADDR_W-1:0] CH_OFS = g;
      wire [`ICC_ADDR_W-1:0] ctrl_addr;
      wire [`ICC_ADDR_W-1:0] buf_addr;
      wire ctrl_wr;
      wire buf_rd;
      wire pin_s;
      wire stopped;
      wire prescaled;
      wire capt;
      wire fifo_ne;
      wire fifo_full;
      wire [WIDTH-1:0] base_sel;
      reg [15:0] ctrl_q;
      reg pin_d_q;
      reg [3:0] pres_q;
      reg [1:0] cpi_q;
      reg ovf_q;
      reg evt;
      reg fire;
      reg [2:0] mode;
      wire rise;
      wire fall;

      assign ctrl_addr = `ICC_CTRL_BASE + CH_OFS;
      assign buf_addr = `ICC_BUF_BASE + CH_OFS;
      assign ctrl_wr = reg_wr && (reg_addr == ctrl_addr);
      assign buf_rd = reg_rd && (reg_addr == buf_addr);

      // ****************************************
      // Pin synchroniser and edge detect
      // ****************************************
      // [RULE18] two-flop pin synchroniser
      icc_sync u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pin_in(capture_input_pin[g]),
        .pin_sync_q(pin_s)
      );

      // The delayed copy resets low, the idle level of the pin, so no
      // false edge follows reset.
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          pin_d_q <= 1'b0;
        end else begin
          pin_d_q <= pin_s;
        end
      end
      assign rise = pin_s && !pin_d_q;
      assign fall = !pin_s && pin_d_q;

      // ****************************************
      // Event qualification
      // ****************************************
      always @* begin
        mode = ctrl_q[`ICC_MODE_LSB+2:`ICC_MODE_LSB];
      end
      // [RULE12] idle-stop gating
      assign stopped = ctrl_q[`ICC_SIDL_BIT] && cpu_idle;
      assign prescaled = (mode == `ICC_MODE_DIV4) ||
                         (mode == `ICC_MODE_DIV16);

      // [RULE2] edge qualification per mode
      always @* begin
        evt = 1'b0;
        case (mode)
          `ICC_MODE_BOTH: evt = rise || fall;
          `ICC_MODE_FALL: evt = fall;
          `ICC_MODE_RISE: evt = rise;
          // [RULE3] edge prescaler terminal count
          `ICC_MODE_DIV4: evt = rise && (pres_q == `ICC_DIV4_LAST);
          `ICC_MODE_DIV16: evt = rise && (pres_q == `ICC_DIV16_LAST);
          // [RULE4] disabled modes
          default: evt = 1'b0;
        endcase
        if (stopped) begin
          evt = 1'b0;
        end
      end

      // [RULE6] captures per interrupt
      always @* begin
        fire = 1'b0;
        if (evt) begin
          // [RULE7] every-edge mode interrupts each capture
          fire = (mode == `ICC_MODE_BOTH) ||
                 (cpi_q == ctrl_q[`ICC_CPI_LSB+1:`ICC_CPI_LSB]);
        end
      end
      assign capt = evt;

      // [RULE5] wake-only mode, rising edge in Sleep or Idle
      assign ch_wake[g] = (mode == `ICC_MODE_WAKE) && rise &&
                          (cpu_sleep || cpu_idle);
      assign ch_event[g] = (fire && !fifo_full) || ch_wake[g];
      assign ch_capture[g] = capt && !fifo_full;

      // ****************************************
      // Control register
      // ****************************************
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          ctrl_q <= `ICC_CTRL_RESET;
        end else if (ctrl_wr) begin
          // [RULE16] only implemented bits are stored
          ctrl_q <= reg_wdata & `ICC_CTRL_WMASK;
        end
      end

      // ****************************************
      // Edge prescaler
      // ****************************************
      // A control write restarts the count, so a new mode never
      // inherits a half-counted group of edges.
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          pres_q <= 4'h0;
        end else if (ctrl_wr) begin
          pres_q <= 4'h0;
        end else if (!stopped && rise && prescaled) begin
          if (mode == `ICC_MODE_DIV4 && pres_q == `ICC_DIV4_LAST) begin
            pres_q <= 4'h0;
          end else begin
            pres_q <= pres_q + 4'h1;
          end
        end
      end

      // ****************************************
      // Capture count for interrupt pacing
      // ****************************************
      // Dropped captures are not counted, so pacing follows stored words.
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          cpi_q <= 2'h0;
        end else if (ctrl_wr) begin
          cpi_q <= 2'h0;
        end else if (ch_capture[g]) begin
          cpi_q <= fire ? 2'h0 : cpi_q + 2'h1;
        end
      end

      // ****************************************
      // Capture buffer
      // ****************************************
      // [RULE11] time base select
      assign base_sel = ctrl_q[`ICC_TSEL_BIT] ? time_base_a_count :
                        time_base_b_count;
      // [RULE8] capture buffer
      icc_fifo #(.WIDTH(WIDTH), .DEPTH(4), .AW(2)) u_fifo (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clear(1'b0),
        .push(capt),
        .push_data(base_sel),
        .pop(buf_rd),
        .head_data(ch_head[g]),
        .not_empty(fifo_ne),
        .full(fifo_full)
      );

      // ****************************************
      // Overflow flag
      // ****************************************
      // [RULE17] overflow set on full push, cleared when empty
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          ovf_q <= 1'b0;
        end else if (capt && fifo_full) begin
          ovf_q <= 1'b1;
        end else if (!fifo_ne) begin
          ovf_q <= 1'b0;
        end
      end

      // ****************************************
      // Control readback
      // ****************************************
      // [RULE9] [RULE10] hardware status bits in the readback
      // Overflow is masked by not-empty, so a read in the cycle that
      // empties the buffer never shows overflow over an empty buffer.
      assign ch_ctrl_rd[g] = {ctrl_q[15:5], ovf_q && fifo_ne, fifo_ne,
                              ctrl_q[2:0]};
    end
  endgenerate

  // ****************************************
  // DMA requests
  // ****************************************
  // [RULE14] DMA request from the first two channels
  // Registered, so each pulse follows the push of the word it moves.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dma_req <= 2'h0;
    end else begin
      dma_req <= ch_capture[1:0];
    end
  end

  // ****************************************
  // Wake request
  // ****************************************
  // [RULE13] wake request on a capture in Sleep or Idle, or on any wake event
  // Combinational, so the request does not wait for a clock cycle.
  assign wake_req = (|ch_wake) ||
                    ((cpu_sleep || cpu_idle) && |ch_capture);

  // ****************************************
  // Interrupt enable
  // ****************************************
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_en_q <= {NCH{1'b0}};
    end else if (reg_wr && sel_en) begin
      irq_en_q <= reg_wdata[NCH-1:0];
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  // An event in the cycle of a clear write wins over the clear.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_q <= {NCH{1'b0}};
    end else if (reg_wr && sel_clr) begin
      irq_stat_q <= (irq_stat_q & ~reg_wdata[NCH-1:0]) | ch_event;
    end else begin
      irq_stat_q <= irq_stat_q | ch_event;
    end
  end
  assign irq = |(irq_stat_q & irq_en_q);

  // ****************************************
  // Read data
  // ****************************************
  integer i;
  reg [15:0] rd_mux;
  always @* begin
    rd_mux = 16'h0000;
    if (sel_stat) begin
      rd_mux[NCH-1:0] = irq_stat_q;
    end
    if (sel_en) begin
      rd_mux[NCH-1:0] = irq_en_q;
    end
    for (i = 0; i < NCH; i = i + 1) begin
      if (reg_addr == `ICC_CTRL_BASE + i) begin
        rd_mux = ch_ctrl_rd[i];
      end
      if (reg_addr == `ICC_BUF_BASE + i) begin
        rd_mux = ch_head[i];
      end
    end
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule // icc_capture

// *** icc_capture_monitor.sv ***
`include "icc_regs.vh"
// ****
// Port checker.
// ****
module icc_capture_monitor #(
  parameter NCH = 8,
  parameter WIDTH = 16
) (
  input wire sys_clk,
  input wire nrst,
  input wire [`ICC_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire [NCH-1:0] capture_input_pin,
  input wire [WIDTH-1:0] time_base_a_count,
  input wire [WIDTH-1:0] time_base_b_count,
  input wire cpu_idle,
  input wire cpu_sleep,
  input wire irq,
  input wire wake_req,
  input wire [1:0] dma_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] hist_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Recent pin samples, so a transfer can be traced to a pin edge.
  always @(posedge sys_clk) begin
    hist_q <= {hist_q[5:0], capture_input_pin[0]};
  end
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0) else $error("stray read data");
  ctrl_resv_a: assert property (
    $past(reg_rd) && $past(reg_addr) < 5'h08 |->
    (reg_rdata & 16'hdf00) == 16'h0) else $error("reserved bits set");
  unmapped_zero_a: assert property (
    $past(reg_rd) && $past(reg_addr) > 5'h12 |-> reg_rdata == 16'h0)
    else $error("unmapped read not zero");
  ovf_full_a: assert property (
    $past(reg_rd) && $past(reg_addr) < 5'h08 && reg_rdata[4] |->
    reg_rdata[3]) else $error("overflow with empty buffer");
  stat_width_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 5'h10 |-> reg_rdata[15:8] == 8'h0)
    else $error("status beyond channel count");
  wake_sleep_a: assert property (
    wake_req |-> cpu_sleep || cpu_idle) else $error("wake while running");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(reg_wr)) else $error("irq dropped by itself");
  dma_edge_a: assert property (
    dma_req[0] |-> hist_q[6:1] != 6'h00 && hist_q[6:1] != 6'h3f)
    else $error("transfer without pin edge");
  dma_pulse_a: assert property (
    dma_req[1] |=> !dma_req[1]) else $error("transfer request too long");
endmodule // icc_capture_monitor

bind icc_capture icc_capture_monitor #(.NCH(NCH), .WIDTH(WIDTH))
  icc_capture_monitor_i (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .capture_input_pin, .time_base_a_count,
  .time_base_b_count, .cpu_idle, .cpu_sleep, .irq, .wake_req, .dma_req);

// *** icc_src.sv ***
// ****
// Pin source.
// ****
module icc_src #(
  parameter NCH = 8
) (
  input wire sys_clk,
  output logic [NCH-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin = '0;
  // Each level is held for gap plus one cycles.
  task automatic toggle(input int ch, input int n, input int gap);
    repeat (n) begin
      @(posedge sys_clk);
      pin[ch] <= ~pin[ch];
      repeat (gap) @(posedge sys_clk);
    end
  endtask
endmodule // icc_src

// *** tb.sv ***
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
// ****
// Bench.
// ****
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, nrst, reg_wr, reg_rd, cpu_idle, cpu_sleep, irq, wake_req;
  logic ts, sid, idl;
  logic [1:0] cpi, dma_req;
  logic [2:0] md;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v, prev;
  logic [7:0] pins;
  logic [14:0] cnt;
  int n_fail, checks, seed, caps, st, thr, k, ndma, nwake, d0, ch;
  icc_src icc_src_i (.sys_clk(sys_clk), .pin(pins));
  icc_capture icc_capture_i (.sys_clk, .nrst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .capture_input_pin(pins),
    .time_base_a_count({1'b0, cnt}), .time_base_b_count({1'b1, cnt}),
    .cpu_idle, .cpu_sleep, .irq, .wake_req, .dma_req);
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cnt <= cnt + 15'h1;
    ndma <= ndma + dma_req[0] + dma_req[1];
    nwake <= nwake + wake_req;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  function automatic int ecaps(int m, int n);
    case (m)
      1: return n;
      2: return n / 2;
      3: return (n + 1) / 2;
      4: return (n + 1) / 8;
      5: return (n + 1) / 32;
      default: return 0;
    endcase
  endfunction
  task automatic test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    test_done;
  end
  initial begin
    {nrst, reg_wr, reg_rd, cpu_idle, cpu_sleep, reg_addr} = '0;
    {reg_wdata, cnt, ndma, nwake, seed} = {31'h0, 32'h0, 32'h0, 32'd43944};
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(5'h01);
    `CHK(v, 16'h0000)
    wr(5'h01, 16'hffff);
    rd(5'h01);
    `CHK(v, 16'h20e7)
    wr(5'h01, 16'h0000);
    rd(5'h1f);
    `CHK(v, 16'h0000)
    for (int it = 0; it < 16; it++) begin
      md = 3'(it % 7);
      {ts, sid, idl, cpi} = 5'($random(seed));
      ch = $random(seed) & 7;
      k = 2 * (4 + ($random(seed) & 15));
      cpu_idle <= idl;
      wr(5'(ch), {2'b0, sid, 5'b0, ts, cpi, 2'b0, md});
      wr(5'h12, 16'h00ff);
      wr(5'h11, 16'h00ff);
      d0 = ndma;
      icc_src_i.toggle(ch, k, 3 + ($random(seed) & 3));
      repeat (6) @(posedge sys_clk);
      cpu_idle <= 1'b0;
      caps = (sid & idl) ? 0 : ecaps(md, k);
      st = caps < 4 ? caps : 4;
      thr = (md == 1) ? 0 : cpi;
      #1;
      `CHK(ndma - d0, (ch < 2) ? st : 0)
      `CHK(irq, caps > thr)
      rd(5'h10);
      `CHK(v[ch], caps > thr)
      rd(5'(ch));
      `CHK(v[4:3], {caps > 4, caps > 0})
      prev = 16'h0;
      for (int j = 0; j < st; j++) begin
        rd(5'h08 + 5'(ch));
        `CHK(v[15], ~ts)
        `CHK(v[14:0] > prev[14:0], 1'b1)
        prev = v;
      end
      rd(5'(ch));
      `CHK(v[4:3], 2'b00)
      wr(5'h11, 16'h0000);
      `CHK(irq, 1'b0)
      wr(5'h11, 16'h00ff);
      wr(5'h12, 16'h00ff);
      `CHK(irq, 1'b0)
      $display("test %0d mode %0d done", it, md);
    end
    wr(5'h00, 16'h0007);
    icc_src_i.toggle(0, 2, 4);
    repeat (6) @(posedge sys_clk);
    #1;
    `CHK(irq, 1'b0)
    cpu_sleep <= 1'b1;
    d0 = nwake;
    icc_src_i.toggle(0, 2, 4);
    repeat (6) @(posedge sys_clk);
    #1;
    `CHK(irq, 1'b1)
    `CHK(nwake > d0, 1'b1)
    rd(5'h00);
    `CHK(v[3], 1'b0)
    $display("test wake done");
    test_done;
  end
endmodule // tb
